// ### rtl/wac_pkg.sv
// Package for watchdog answer and off-state cause registers
`default_nettype none
package wac_pkg;
  // Register identifiers on the internal command port
  localparam logic [1:0] REG_WD_STATUS = 2'h0;
  localparam logic [1:0] REG_RESPONSE_BYTE_FIELD = 2'h1;
  localparam logic [1:0] REG_OFF_CAUSE = 2'h2;
  // Reset values
  localparam logic [7:0] OFF_CAUSE_RST = 8'h00;
  localparam logic [7:0] ANSWER_RST = 8'h00;
  // Answers needed in window 1 for mode 0
  localparam logic [2:0] EARLY_COUNT_M0 = 3'h4;
  // Bit positions of the off-state cause register
  localparam int CAUSE_STARTUP_TO = 7;
  localparam int CAUSE_EC_PWDN = 6;
  localparam int CAUSE_SUPPLY_OV = 5;
  localparam int CAUSE_REG_FAIL = 4;
  localparam int CAUSE_CRC = 3;
  localparam int CAUSE_RESET_STATE_TIMEOUT_CAUSE = 2;
  localparam int CAUSE_SYSCLK = 1;
  localparam int CAUSE_POR = 0;
  // Off-state cause events, one bit each
  typedef struct packed {
    logic startup_timeout_cause;
    logic error_count_powerdown_cause;
    logic supply_overvoltage_cause;
    logic regulator_failure_cause;
    logic config_memory_crc_cause;
    logic reset_state_timeout_cause;
    logic system_clock_failure_cause;
    logic poweron_reset_cause;
  } wac_cause_s;
  // Watchdog window events from the timing logic
  typedef struct packed {
    logic cycle_end;
    logic in_window1;
    logic in_closed;
  } wac_wd_s;
endpackage
`default_nettype wire

// ### rtl/wac_regs.sv
// Watchdog early flag, answer register and off-state cause latch
// Notes on behaviour
// - Mode 0: early flag set if at least 4 answers in window 1, else cleared.
// - Mode 1: early flag set if one answer in closed window, else cleared.
// - Early flag updated at every cycle end; cleared by status read.
// - Eight-bit write-only answer register takes each host answer byte.
// - Answer register initialised at power-on reset and RESET state entry.
// - Cause register read-only, resets to zero, cleared by read access.
// - Bit 7 set by start-up timeout forcing OFF.
// - Bit 6 set by error count power-down threshold forcing OFF.
// - Bit 5 set by supply overvoltage; held after the event ends until read.
// - Bit 4 set by regulator or internal supply failure forcing OFF.
// - Bit 3 set by configuration memory CRC error forcing OFF.
// - Bit 2 set by RESET state timeout forcing OFF.
// - Bit 1 set by system clock failure forcing OFF.
// - Bit 0 set by power-on reset event forcing OFF.
`timescale 1ns/1ps
`default_nettype none
module wac_regs (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Register command port, one-cycle strobes
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  // Watchdog configuration and timing
  input wire logic i_watchdog_mode_select,
  input wire logic i_reset_state_entry,
  input wire wac_pkg::wac_wd_s i_wd,
  // Off-state cause events
  input wire wac_pkg::wac_cause_s i_cause,
  // Read data and status
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_early_response_flag,
  output logic [7:0] o_response_byte_field,
  output logic o_answer_strobe,
  output logic [7:0] o_off_state_cause_latch
);
  // Early flag and its next value
  logic early_q;
  logic early_d;
  // Answers counted in window 1 of the running cycle
  logic [2:0] win_cnt_q;
  logic [2:0] win_cnt_d;
  // Answer seen in the closed window of the running cycle
  logic closed_seen_q;
  logic closed_seen_d;
  // Last answer byte and its one-cycle strobe
  logic [7:0] answer_q;
  logic [7:0] answer_d;
  logic ans_stb_q;
  logic ans_stb_d;
  // Off-state cause latch
  logic [7:0] cause_q;
  logic [7:0] cause_d;
  // Registered read port
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  // Decoded accesses
  logic answer_wr;
  logic status_rd;
  logic cause_rd;
  // Watchdog verdict terms
  logic win1_answer;
  logic closed_answer;
  logic win_cnt_full;
  logic [3:0] win_cnt_next;
  logic early_m0;
  logic early_m1;
  logic early_hit;
  // Cause events as a vector, one bit per cause position
  logic [7:0] cause_set;

  // Command decode; only the answer slot is writable
  assign answer_wr = i_wr && (i_addr == wac_pkg::REG_RESPONSE_BYTE_FIELD);
  assign status_rd = i_rd && (i_addr == wac_pkg::REG_WD_STATUS);
  assign cause_rd = i_rd && (i_addr == wac_pkg::REG_OFF_CAUSE);

  // Answer qualified by the window it lands in
  assign win1_answer = answer_wr && i_wd.in_window1;
  assign closed_answer = answer_wr && i_wd.in_closed;

  // Window 1 count, saturating so a chatty host cannot wrap it
  assign win_cnt_full = (win_cnt_q == 3'h7);
  assign win_cnt_d = i_wd.cycle_end ? 3'h0 :
    ((win1_answer && !win_cnt_full) ? win_cnt_q + 3'h1 : win_cnt_q);

  // Closed window memory, dropped at each cycle end
  assign closed_seen_d = i_wd.cycle_end ? 1'b0 : (closed_seen_q || closed_answer);

  // Mode 0 verdict; the spare bit keeps the sum from wrapping at seven
  assign win_cnt_next = {1'b0, win_cnt_q} + {3'h0, win1_answer};
  assign early_m0 = (win_cnt_next >= {1'b0, wac_pkg::EARLY_COUNT_M0});
  // Mode 1 verdict, an answer on the last cycle included
  assign early_m1 = closed_seen_q || closed_answer;
  // Verdict chosen by the mode select
  assign early_hit = i_watchdog_mode_select ? early_m1 : early_m0;

  // Cycle end update wins over a status read clear
  assign early_d = i_wd.cycle_end ? early_hit : (status_rd ? 1'b0 : early_q);

  // RESET state entry beats a same-cycle write
  assign answer_d = i_reset_state_entry ? wac_pkg::ANSWER_RST :
    (answer_wr ? i_wdata : answer_q);
  // Strobe marks each answer write, also one that RESET state entry discards
  assign ans_stb_d = answer_wr;

  // Cause events mapped onto their bit positions
  assign cause_set[wac_pkg::CAUSE_STARTUP_TO] = i_cause.startup_timeout_cause;
  assign cause_set[wac_pkg::CAUSE_EC_PWDN] = i_cause.error_count_powerdown_cause;
  assign cause_set[wac_pkg::CAUSE_SUPPLY_OV] = i_cause.supply_overvoltage_cause;
  assign cause_set[wac_pkg::CAUSE_REG_FAIL] = i_cause.regulator_failure_cause;
  assign cause_set[wac_pkg::CAUSE_CRC] = i_cause.config_memory_crc_cause;
  assign cause_set[wac_pkg::CAUSE_RESET_STATE_TIMEOUT_CAUSE] = i_cause.reset_state_timeout_cause;
  assign cause_set[wac_pkg::CAUSE_SYSCLK] = i_cause.system_clock_failure_cause;
  assign cause_set[wac_pkg::CAUSE_POR] = i_cause.poweron_reset_cause;

  // Per-bit latch: a read clears, a new event sets
  // Set wins over the read clear, so no event is lost
  for (genvar b = 0; b < $bits(cause_q); b++) begin : g_cause
    assign cause_d[b] = (cause_q[b] && !cause_rd) || cause_set[b];
  end

  // Read mux: value before the clear is returned
  // Reads of the answer slot and the spare slot give zero
  assign rdata_d = cause_rd ? cause_q :
    (status_rd ? {7'h00, early_q} : 8'h00);
  // Every read strobe earns one valid pulse
  assign rvalid_d = i_rd;

  // Early flag register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      early_q <= 1'b0;
    end else begin
      early_q <= early_d;
    end
  end

  // Window 1 answer counter
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      win_cnt_q <= 3'h0;
    end else begin
      win_cnt_q <= win_cnt_d;
    end
  end

  // Closed window answer memory
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      closed_seen_q <= 1'b0;
    end else begin
      closed_seen_q <= closed_seen_d;
    end
  end

  // Answer byte register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      answer_q <= wac_pkg::ANSWER_RST;
    end else begin
      answer_q <= answer_d;
    end
  end

  // Answer strobe register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ans_stb_q <= 1'b0;
    end else begin
      ans_stb_q <= ans_stb_d;
    end
  end

  // Off-state cause latch register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cause_q <= wac_pkg::OFF_CAUSE_RST;
    end else begin
      cause_q <= cause_d;
    end
  end

  // Read data register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Read valid register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rvalid_d;
    end
  end

  // Outputs straight from their registers
  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;
  assign o_early_response_flag = early_q;
  assign o_response_byte_field = answer_q;
  assign o_answer_strobe = ans_stb_q;
  assign o_off_state_cause_latch = cause_q;
endmodule
`default_nettype wire

// ### bench/wac_regs_checker.sv
// Port timing checker for the watchdog and cause registers
`timescale 1ns/1ps
`default_nettype none
module wac_regs_checker (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Register command port
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  // Watchdog and cause inputs
  input wire logic i_reset_state_entry,
  input wire wac_pkg::wac_wd_s i_wd,
  input wire wac_pkg::wac_cause_s i_cause,
  // Design outputs
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_early_response_flag,
  input wire logic [7:0] o_response_byte_field,
  input wire logic o_answer_strobe,
  input wire logic [7:0] o_off_state_cause_latch
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Decoded accesses
  wire logic rd_st = i_rd && i_addr == wac_pkg::REG_WD_STATUS;
  wire logic rd_oc = i_rd && i_addr == wac_pkg::REG_OFF_CAUSE;
  wire logic wr_an = i_wr && i_addr == wac_pkg::REG_RESPONSE_BYTE_FIELD;
  AST_RV: assert property (i_rd |=> o_rvalid) else $error("rvalid");
  AST_RC: assert property (rd_oc |=> o_rdata == $past(o_off_state_cause_latch))
    else $error("rd");
  AST_CL: assert property (rd_oc && i_cause == 8'h00 |=>
    o_off_state_cause_latch == 8'h00) else $error("cl");
  AST_ST: assert property (i_cause != 8'h00 |=>
    (o_off_state_cause_latch & $past(i_cause)) == $past(i_cause)) else $error("set");
  AST_HD: assert property (!i_rd && i_cause == 8'h00 |=>
    $stable(o_off_state_cause_latch)) else $error("hd");
  AST_AN: assert property (wr_an |=> o_answer_strobe &&
    (o_response_byte_field == $past(i_wdata) || $past(i_reset_state_entry))) else $error("an");
  AST_NA: assert property (!wr_an |=> !o_answer_strobe) else $error("na");
  AST_RS: assert property (i_reset_state_entry && !i_wr |=>
    o_response_byte_field == wac_pkg::ANSWER_RST) else $error("rs");
  AST_FS: assert property (!i_wd.cycle_end && !rd_st |=>
    $stable(o_early_response_flag)) else $error("fs");
  AST_FR: assert property (rd_st && !i_wd.cycle_end |=> !o_early_response_flag &&
    o_rdata == {7'h00, $past(o_early_response_flag)}) else $error("fr");
endmodule
bind wac_regs wac_regs_checker wac_regs_checker_inst (.*);
`default_nettype wire

// ### bench/wac_host.sv
// Host model issuing one-cycle register strobes
`timescale 1ns/1ps
`default_nettype none
module wac_host (
  // Clock
  input wire logic i_mclk,
  // Read data from the register port
  input wire logic [7:0] i_rdata,
  // Access strobes, address and write data
  output logic o_rd,
  output logic o_wr,
  output logic [1:0] o_addr,
  output logic [7:0] o_wdata
);
  initial {o_rd, o_wr, o_addr, o_wdata} = 12'h000;
  // One access, data lines inverted once released
  task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge i_mclk) #1;
    {o_rd, o_wr, o_addr, o_wdata} = {!w, w, a, d};
    @(posedge i_mclk) #1;
    {o_rd, o_wr, o_wdata} = {2'h0, ~d};
    q = i_rdata;
  endtask
endmodule
`default_nettype wire

// ### bench/test_wac_regs.sv
// Self-checking bench for the watchdog and cause registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t %h %h", $time, a, e); end end
module test_wac_regs;
  logic i_mclk = 1'b0, i_rst = 1'b1, mode = 1'b0, rse = 1'b0, rd, wr, flag, rvalid, strobe;
  wac_pkg::wac_wd_s i_wd = '0;
  wac_pkg::wac_cause_s i_cause = '0;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, ans, latch, q;
  int n_errors = 0, compares = 0, cyc = 0;
  always #10 i_mclk = ~i_mclk;
  wac_host wac_host_inst (.i_mclk, .i_rdata(rdata), .o_rd(rd), .o_wr(wr), .o_addr(addr),
    .o_wdata(wdata));
  wac_regs wac_regs_inst (.i_mclk, .i_rst, .i_rd(rd), .i_wr(wr), .i_addr(addr),
    .i_wdata(wdata), .i_watchdog_mode_select(mode), .i_reset_state_entry(rse), .i_wd,
    .i_cause, .o_rdata(rdata), .o_rvalid(rvalid), .o_early_response_flag(flag),
    .o_response_byte_field(ans), .o_answer_strobe(strobe), .o_off_state_cause_latch(latch));
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
    wac_host_inst.acc(1'b0, a, 8'h00, q);
    `CHK(q, e)
    `CHK(rvalid, 1'b1)
  endtask
  // Answers n bytes in the chosen window, then ends the cycle
  task automatic wd_cycle(input logic m, input int n, input logic e);
    mode = m;
    i_wd = {1'b0, !m, m};
    repeat (n) wac_host_inst.acc(1'b1, wac_pkg::REG_RESPONSE_BYTE_FIELD, 8'h5a, q);
    @(posedge i_mclk) #1;
    i_wd = 3'h4;
    @(posedge i_mclk) #1;
    i_wd = '0;
    `CHK(flag, e)
  endtask
  task automatic final_report;
    $display("counts: %0d compares, %0d errors", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Cycle ceiling against hangs
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      final_report;
    end
  end
  initial begin
    repeat (12) @(posedge i_mclk);
    #1 i_rst = 0;
    rd_chk(wac_pkg::REG_OFF_CAUSE, wac_pkg::OFF_CAUSE_RST);
    rd_chk(wac_pkg::REG_RESPONSE_BYTE_FIELD, 8'h00);
    for (int i = 0; i < 8; i++) begin
      i_cause = 8'h01 << i;
      @(posedge i_mclk) #1;
      i_cause = '0;
      `CHK(latch, 8'h01 << i)
      rd_chk(wac_pkg::REG_OFF_CAUSE, 8'h01 << i);
      rd_chk(wac_pkg::REG_OFF_CAUSE, 8'h00);
      `CHK(latch, 8'h00)
    end
    i_cause = 8'h20;
    rd_chk(wac_pkg::REG_OFF_CAUSE, 8'h20);
    i_cause = '0;
    rd_chk(wac_pkg::REG_OFF_CAUSE, 8'h20);
    $display("test causes done");
    wac_host_inst.acc(1'b1, wac_pkg::REG_RESPONSE_BYTE_FIELD, 8'hc3, q);
    `CHK(ans, 8'hc3)
    `CHK(strobe, 1'b1)
    rse = 1;
    @(posedge i_mclk) #1;
    rse = 0;
    `CHK(ans, wac_pkg::ANSWER_RST)
    wd_cycle(1'b1, 1, 1'b1);
    wd_cycle(1'b1, 0, 1'b0);
    wd_cycle(1'b0, 4, 1'b1);
    wd_cycle(1'b0, 3, 1'b0);
    wd_cycle(1'b0, 4, 1'b1);
    rd_chk(wac_pkg::REG_WD_STATUS, 8'h01);
    `CHK(flag, 1'b0)
    $display("test watchdog done");
    i_cause = 8'h81;
    @(posedge i_mclk) #1;
    i_cause = '0;
    `CHK(latch, 8'h81)
    i_rst = 1'b1;
    @(posedge i_mclk) #1;
    i_rst = 1'b0;
    rd_chk(wac_pkg::REG_OFF_CAUSE, wac_pkg::OFF_CAUSE_RST);
    `CHK(flag, 1'b0)
    $display("test reset done");
    final_report;
  end
endmodule
`default_nettype wire
